// ===== hw/can_af_pkg.sv
// Purpose: shared constants and types for the acceptance filter and bit timer
// Assumes: one clock, AXI4-Lite register access, 32-bit data
// Notes: identifier layout is {sid[10:0], eid[17:0]} in 29 bits
package can_af_pkg;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK0  = 8'h10;
  localparam logic [7:0] OFS_MASK1  = 8'h14;
  localparam logic [7:0] OFS_FILT0  = 8'h20;
  localparam logic [7:0] OFS_FILT5  = 8'h34;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing field positions
  localparam int TM_PRE = 0;
  localparam int TM_PRP = 8;
  localparam int TM_PH1 = 12;
  localparam int TM_PH2 = 16;
  localparam int TM_SJW = 20;
  localparam int TM_SAM = 24;
  localparam logic [24:0] TIMING_RST = 25'h0000000;
  localparam logic [3:0]  PH2_MIN_TQ = 4'h2;
  localparam logic [3:0]  SYNC_TQ    = 4'h1;
  localparam logic        CFG_RST    = 1'b1;

  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_PROP = 2'b01,
    SEG_PH1  = 2'b11,
    SEG_PH2  = 2'b10
  } seg_t;

  typedef struct packed {
    logic        ext;
    logic [28:0] id;
    logic [15:0] data;
  } frame_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_in_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_out_t;
endpackage

// ===== hw/can_accept_timing.sv
// Purpose: acceptance filtering, buffer steering and bit timing of a CAN receiver
// Assumes: frames arrive already assembled on mclk_in; rx pin is asynchronous
// Notes: timing lengths are programmed as value minus one
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - a cleared mask bit makes that identifier bit match unconditionally
// - a set mask bit matches only when received bit equals filter bit, except bits 1:0 of a standard frame
// - filters 0,1 with mask 0 feed buffer zero; filters 2-5 with mask 1 feed one
// - buffer one load records the matching filter number as three-bit code
// - codes 000/001 in buffer one only come from a rollover with enable set
// - buffer zero control shows rollover twice plus its one-bit hit
// - several matches record the lowest-numbered matching filter
// - ascending evaluation; each frame lands in at most one buffer, zero first
// - mask and filter writes take effect only in configuration mode
// - mask and filter reads give zero outside configuration mode
// - one time quantum lasts two times prescaler plus one oscillator periods
// - each bit starts with a one-quantum alignment segment
// - propagation segment lasts one to eight quanta
// - phase one is one to eight quanta, lengthened by resync
// - phase two is two to eight quanta, shortened by resync
// - single sample at the phase one to phase two boundary
// - triple sample adds points one and half quantum earlier; majority vote
// - programmed phase two length never below two quanta
// - only recessive-to-dominant edges synchronise
// - hard sync restarts the bit counter at the alignment segment
// - edges outside the alignment segment adjust the phase segments
// - any adjustment is limited to the jump width of one to four quanta
// - standard frames filter the first two data bytes with extended bits
// - with rollover, a frame for full buffer zero goes to buffer one
module can_accept_timing import can_af_pkg::*; (
  // clock and reset
  input  wire logic     mclk_in,
  input  wire logic     reset_n_in,
  // register bus
  input  wire axi_in_t  axi_in,
  output axi_out_t      axi_out,
  // assembled frames
  input  wire logic     frame_valid_in,
  input  wire frame_t   frame_in,
  output logic          load_zero_out,
  output logic          load_one_out,
  // bus line
  input  wire logic     rx_in,
  input  wire logic     bus_idle_in,
  output logic          bit_value_out,
  output logic          bit_strobe_out,
  output logic [1:0]    segment_out
);
  typedef struct packed {
    logic             aw_v;
    logic [7:0]       aw_a;
    logic             w_v;
    logic [31:0]      w_d;
    logic [3:0]       w_s;
    logic             b_v;
    logic [1:0]       b_r;
    logic             r_v;
    logic [1:0]       r_r;
    logic [31:0]      r_d;
    logic             cfg;
    logic             roll_en;
    logic [24:0]      tim;
    logic [1:0][28:0] mask;
    logic [5:0][28:0] filt;
    logic             full0;
    logic             full1;
    logic             hit0;
    logic             rolled;
    logic [2:0]       code1;
    logic             ld0;
    logic             ld1;
    logic             rx1;
    logic             rx2;
    logic             rx3;
    logic [6:0]       pre;
    seg_t             seg;
    logic [3:0]       q;
    logic [3:0]       ext;
    logic [3:0]       shrt;
    logic             synced;
    logic             s1;
    logic             s2;
    logic             bit_v;
    logic             bit_s;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic hit(input logic [28:0] m, input logic [28:0] f,
                               input logic [28:0] id);
    return ((id ^ f) & m) == 29'h00000000;
  endfunction

  function automatic logic [3:0] min4(input logic [3:0] a, input logic [3:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic is_af(input logic [7:0] a);
    return (a >= OFS_MASK0 && a <= OFS_MASK1) || (a >= OFS_FILT0 && a <= OFS_FILT5);
  endfunction

  // decoded timing
  logic [5:0]  quantum_prescaler;
  logic [3:0]  prp_len;
  logic [3:0]  ph1_len;
  logic [3:0]  ph2_len;
  logic [3:0]  sjw_len;
  logic [3:0]  seg_len;
  logic [6:0]  pre_lim;
  logic        tq_tick;
  logic        half_tick;
  logic        fall;
  logic [28:0] key;
  logic [5:0]  match;
  logic [2:0]  low;
  logic [4:0]  err_q;
  logic [31:0] rd;
  logic        rd_ok;
  logic        wr_go;
  logic        bit_end;

  always_comb begin
    quantum_prescaler     = st_r.tim[TM_PRE +: 6];
    prp_len = {1'b0, st_r.tim[TM_PRP +: 3]} + 4'h1;
    ph1_len = {1'b0, st_r.tim[TM_PH1 +: 3]} + 4'h1;
    ph2_len = {1'b0, st_r.tim[TM_PH2 +: 3]} + 4'h1;
    if (ph2_len < PH2_MIN_TQ) ph2_len = PH2_MIN_TQ;
    sjw_len = {2'b00, st_r.tim[TM_SJW +: 2]} + 4'h1;
    pre_lim = {quantum_prescaler, 1'b1};
    tq_tick = st_r.pre == pre_lim;
    half_tick = st_r.pre == {1'b0, quantum_prescaler};
    fall = st_r.rx3 & ~st_r.rx2;
    case (st_r.seg)
      SEG_SYNC: seg_len = SYNC_TQ;
      SEG_PROP: seg_len = prp_len;
      SEG_PH1:  seg_len = ph1_len + st_r.ext;
      SEG_PH2:  seg_len = ph2_len - st_r.shrt;
      default:  seg_len = SYNC_TQ;
    endcase
    bit_end = tq_tick && st_r.seg == SEG_PH2 && st_r.q + 4'h1 >= seg_len;
    // standard frames reuse the extended bits on data bytes 0 and 1
    key = frame_in.ext ? frame_in.id : {frame_in.id[28:18], frame_in.data, 2'b00};
    for (int i = 0; i < 6; i++) begin
      match[i] = hit(((i < 2) ? st_r.mask[0] : st_r.mask[1])
                     & (frame_in.ext ? 29'h1FFFFFFF : 29'h1FFFFFFC), st_r.filt[i], key);
    end
    low = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (match[i]) low = 3'(i);
    end
    // quanta elapsed since alignment end, used as phase error
    err_q = (st_r.seg == SEG_PROP) ? {1'b0, st_r.q} + 5'h1
                                   : {1'b0, prp_len} + {1'b0, st_r.q} + 5'h1;
    rd_ok = 1'b1;
    case (axi_in.araddr)
      OFS_CTRL:   rd = {30'h00000000, st_r.roll_en, st_r.cfg};
      OFS_TIMING: rd = {7'h00, st_r.tim};
      OFS_STATUS: rd = {19'h00000, st_r.bit_v, 2'h0, st_r.full1, st_r.full0, 1'b0,
                        st_r.code1, 1'b0, st_r.rolled, st_r.rolled, st_r.hit0};
      OFS_MASK0:  rd = {3'h0, st_r.mask[0]};
      OFS_MASK1:  rd = {3'h0, st_r.mask[1]};
      default: begin
        rd = 32'h00000000;
        rd_ok = 1'b0;
        for (int i = 0; i < 6; i++) begin
          if (axi_in.araddr == OFS_FILT0 + 8'(4 * i)) begin
            rd = {3'h0, st_r.filt[i]};
            rd_ok = 1'b1;
          end
        end
      end
    endcase
    if (is_af(axi_in.araddr) && !st_r.cfg) rd = 32'h00000000;
    wr_go = st_r.aw_v && st_r.w_v && !st_r.b_v;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.ld0 = 1'b0;
    st_nxt.ld1 = 1'b0;
    st_nxt.bit_s = 1'b0;
    // write address and data are taken independently
    if (axi_in.awvalid && !st_r.aw_v) begin
      st_nxt.aw_v = 1'b1;
      st_nxt.aw_a = axi_in.awaddr;
    end
    if (axi_in.wvalid && !st_r.w_v) begin
      st_nxt.w_v = 1'b1;
      st_nxt.w_d = axi_in.wdata;
      st_nxt.w_s = axi_in.wstrb;
    end
    if (st_r.b_v && axi_in.bready) st_nxt.b_v = 1'b0;
    if (wr_go) begin
      st_nxt.aw_v = 1'b0;
      st_nxt.w_v = 1'b0;
      st_nxt.b_v = 1'b1;
      st_nxt.b_r = RESP_OKAY;
      case (st_r.aw_a)
        OFS_CTRL: begin
          st_nxt.cfg = st_r.w_s[0] ? st_r.w_d[0] : st_r.cfg;
          st_nxt.roll_en = st_r.w_s[0] ? st_r.w_d[1] : st_r.roll_en;
        end
        OFS_TIMING: st_nxt.tim = 25'(merge({7'h00, st_r.tim}, st_r.w_d, st_r.w_s));
        // write one to clear; a load in the same cycle wins below
        OFS_STATUS: begin
          if (st_r.w_s[1] && st_r.w_d[8]) st_nxt.full0 = 1'b0;
          if (st_r.w_s[1] && st_r.w_d[9]) st_nxt.full1 = 1'b0;
        end
        default: begin
          if (!is_af(st_r.aw_a)) st_nxt.b_r = RESP_SLVERR;
          for (int i = 0; i < 2; i++) begin
            if (st_r.cfg && st_r.aw_a == OFS_MASK0 + 8'(4 * i)) begin
              st_nxt.mask[i] = 29'(merge({3'h0, st_r.mask[i]}, st_r.w_d, st_r.w_s));
            end
          end
          for (int i = 0; i < 6; i++) begin
            if (st_r.cfg && st_r.aw_a == OFS_FILT0 + 8'(4 * i)) begin
              st_nxt.filt[i] = 29'(merge({3'h0, st_r.filt[i]}, st_r.w_d, st_r.w_s));
            end
          end
        end
      endcase
    end
    if (st_r.r_v && axi_in.rready) st_nxt.r_v = 1'b0;
    if (axi_in.arvalid && !st_r.r_v) begin
      st_nxt.r_v = 1'b1;
      st_nxt.r_d = rd;
      st_nxt.r_r = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // steering: buffer zero first, then rollover, then buffer one
    if (frame_valid_in && (match[0] || match[1]) && !st_r.full0) begin
      st_nxt.full0 = 1'b1;
      st_nxt.ld0 = 1'b1;
      st_nxt.hit0 = low[0];
      st_nxt.rolled = 1'b0;
    end else if (frame_valid_in && (match[0] || match[1]) && st_r.roll_en
                 && !st_r.full1) begin
      st_nxt.full1 = 1'b1;
      st_nxt.ld1 = 1'b1;
      st_nxt.code1 = low;
      st_nxt.hit0 = low[0];
      st_nxt.rolled = 1'b1;
    end else if (frame_valid_in && |match[5:2] && !st_r.full1) begin
      st_nxt.full1 = 1'b1;
      st_nxt.ld1 = 1'b1;
      st_nxt.code1 = (match[0] || match[1]) ? 3'h0 : low;
      if (match[0] || match[1]) begin
        for (int i = 5; i >= 2; i--) begin
          if (match[i]) st_nxt.code1 = 3'(i);
        end
      end
    end
    // bit timing; rx passes two flops before use
    st_nxt.rx1 = rx_in;
    st_nxt.rx2 = st_r.rx1;
    st_nxt.rx3 = st_r.rx2;
    st_nxt.pre = tq_tick ? 7'h00 : st_r.pre + 7'h01;
    if (tq_tick) begin
      if (st_r.seg != SEG_PH1 || st_r.q + 4'h1 < seg_len) st_nxt.s1 = st_r.rx2;
      if (st_r.q + 4'h1 >= seg_len) begin
        st_nxt.q = 4'h0;
        case (st_r.seg)
          SEG_SYNC: st_nxt.seg = SEG_PROP;
          SEG_PROP: st_nxt.seg = SEG_PH1;
          SEG_PH1: begin
            st_nxt.seg = SEG_PH2;
            st_nxt.bit_s = 1'b1;
            // majority of three samples or the boundary sample alone
            st_nxt.bit_v = st_r.tim[TM_SAM] ? ((st_r.s1 & st_r.s2) | (st_r.s1 & st_r.rx2)
                                            | (st_r.s2 & st_r.rx2)) : st_r.rx2;
          end
          default: begin
            st_nxt.seg = SEG_SYNC;
            st_nxt.ext = 4'h0;
            st_nxt.shrt = 4'h0;
            st_nxt.synced = 1'b0;
          end
        endcase
      end else begin
        st_nxt.q = st_r.q + 4'h1;
      end
    end
    if (half_tick && st_r.seg == SEG_PH1 && st_r.q + 4'h1 == seg_len) begin
      st_nxt.s2 = st_r.rx2;
    end
    if (fall && bus_idle_in) begin
      st_nxt.seg = SEG_SYNC;
      st_nxt.q = 4'h0;
      st_nxt.pre = 7'h00;
      st_nxt.ext = 4'h0;
      st_nxt.shrt = 4'h0;
      st_nxt.synced = 1'b1;
      // an edge seen as phase two closes already belongs to the next alignment slot;
      // shortening here would leak into the following bit
    end else if (fall && !st_r.synced && st_r.seg != SEG_SYNC && !bit_end) begin
      st_nxt.synced = 1'b1;
      if (st_r.seg == SEG_PH2) begin
        st_nxt.shrt = min4(ph2_len - st_r.q, sjw_len);
      end else begin
        // saturate so an error of sixteen quanta does not wrap to zero
        st_nxt.ext = min4((err_q > 5'h0F) ? 4'hF : err_q[3:0], sjw_len);
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
      st_r.cfg <= CFG_RST;
      st_r.tim <= TIMING_RST;
      st_r.rx1 <= 1'b1;
      st_r.rx2 <= 1'b1;
      st_r.rx3 <= 1'b1;
      st_r.seg <= SEG_SYNC;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    axi_out.awready = !st_r.aw_v;
    axi_out.wready  = !st_r.w_v;
    axi_out.bvalid  = st_r.b_v;
    axi_out.bresp   = st_r.b_r;
    axi_out.arready = !st_r.r_v;
    axi_out.rvalid  = st_r.r_v;
    axi_out.rdata   = st_r.r_d;
    axi_out.rresp   = st_r.r_r;
  end
  assign load_zero_out  = st_r.ld0;
  assign load_one_out   = st_r.ld1;
  assign bit_value_out  = st_r.bit_v;
  assign bit_strobe_out = st_r.bit_s;
  assign segment_out    = st_r.seg;

  AST_AF_READ_ZERO: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    axi_in.arvalid && !st_r.r_v && !st_r.cfg && is_af(axi_in.araddr)
    |=> axi_out.rdata == 32'h00000000)
    else $error("mask or filter read not zero outside configuration");
  AST_AF_WRITE_LOCK: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    wr_go && !st_r.cfg |=> $stable(st_r.mask) && $stable(st_r.filt))
    else $error("mask or filter changed outside configuration");
  AST_ONE_BUFFER: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !(st_r.ld0 && st_r.ld1))
    else $error("frame loaded into both buffers");
  AST_LOW_CODE_ROLL: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    st_r.ld1 && st_r.code1 < 3'h2 |-> st_r.rolled && $past(st_r.roll_en))
    else $error("low filter code in buffer one without rollover");
  AST_TQ_PERIOD: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    tq_tick && $stable(st_r.tim) |=> st_r.pre == 7'h00 && !tq_tick)
    else $error("prescaler did not restart after a quantum");
  AST_SYNC_ONE: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    tq_tick && st_r.seg == SEG_SYNC && !fall |=> st_r.seg == SEG_PROP)
    else $error("alignment segment longer than one quantum");
  AST_JUMP_LIMIT: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    st_r.ext <= sjw_len && st_r.shrt <= sjw_len)
    else $error("phase adjustment exceeds jump width");
  AST_PH2_MIN: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ph2_len >= PH2_MIN_TQ)
    else $error("phase two below two quanta");
  AST_HARD_SYNC: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    fall && bus_idle_in |=> st_r.seg == SEG_SYNC && st_r.q == 4'h0 ##1 st_r.pre == 7'h01)
    else $error("hard sync did not restart the bit");
  AST_RISE_IGNORED: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !st_r.rx3 && st_r.rx2 && !tq_tick |=> $stable(st_r.seg) && $stable(st_r.q))
    else $error("rising edge moved the bit counter");
endmodule // can_accept_timing

// ===== test/can_node_model.sv
// Purpose: far-side CAN node that drives the receive line one bit at a time
// Assumes: recessive level is 1 and the line idles recessive between frames
// Notes: bit period in clocks is an argument, so fast and slow nodes share one model
`timescale 1ns/1ps
module can_node_model (
  // clock
  input  wire logic clk_in,
  // bus line
  output logic      rx_out
);
  initial rx_out = 1'b1;

  // lsb goes first; the line returns to recessive once the last bit has run out
  task automatic send(input logic [7:0] pat, input int period);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      rx_out <= pat[i];
      repeat (period - 1) @(posedge clk_in);
    end
    @(posedge clk_in);
    rx_out <= 1'b1;
  endtask
endmodule // can_node_model

// ===== test/can_accept_filter_bit_timing_test.sv
// Purpose: self-checking bench for acceptance filtering, buffer steering and bit timing
// Assumes: status bit 12 follows the bus, so status compares mask it out
// Notes: one quantum is four clocks and one bit six quanta, so a bit lasts 24 clocks
`timescale 1ns/1ps
module can_accept_filter_bit_timing_test import can_af_pkg::*;;
  localparam logic [28:0] ID_A = 29'h0ABCDEF1;
  localparam logic [28:0] ID_B = 29'h12345600;
  localparam logic [28:0] ID_S = {11'h2A5, 16'hC3C3, 2'b00};
  localparam logic [31:0] SM   = 32'h00000377;
  localparam logic [7:0]  PAT  = 8'hB2;
  logic        mclk_in        = 1'b0;
  logic        reset_n_in     = 1'b0;
  axi_in_t     axi_in         = '0;
  axi_out_t    axi_out;
  logic        frame_valid_in = 1'b0;
  frame_t      frame_in       = '0;
  logic        bus_idle_in    = 1'b1;
  logic        rx_in;
  logic        load_zero_out;
  logic        load_one_out;
  logic        bit_value_out;
  logic        bit_strobe_out;
  logic [1:0]  segment_out;
  logic [31:0] rd;
  logic [28:0] filt [6] = '{ID_A, ID_B, 29'h00111100, ID_B, ID_S, 29'h00555500};
  int          err_total = 0;
  int          n_tests   = 0;

  always #2 mclk_in = ~mclk_in;

  can_accept_timing can_accept_timing_i (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .axi_in(axi_in), .axi_out(axi_out),
    .frame_valid_in(frame_valid_in), .frame_in(frame_in), .load_zero_out(load_zero_out),
    .load_one_out(load_one_out), .rx_in(rx_in), .bus_idle_in(bus_idle_in),
    .bit_value_out(bit_value_out), .bit_strobe_out(bit_strobe_out), .segment_out(segment_out));

  can_node_model can_node_model_i (.clk_in(mclk_in), .rx_out(rx_in));

  task automatic end_of_test();
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    err_total++;
    $display("ERROR %0t no answer: %s", $time, what);
    end_of_test();
  endtask

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit got;
    got = 0;
    @(posedge mclk_in);
    axi_in.awvalid <= 1'b1;
    axi_in.awaddr  <= a;
    axi_in.wvalid  <= 1'b1;
    axi_in.wdata   <= d;
    axi_in.wstrb   <= 4'hF;
    axi_in.bready  <= 1'b1;
    for (int i = 0; i < 64 && !got; i++) begin
      @(posedge mclk_in);
      if (axi_in.awvalid && axi_out.awready === 1'b1) axi_in.awvalid <= 1'b0;
      if (axi_in.wvalid && axi_out.wready === 1'b1) axi_in.wvalid <= 1'b0;
      if (axi_out.bvalid === 1'b1) begin
        got = 1;
        axi_in.bready <= 1'b0;
        chk(32'(axi_out.bresp), 32'(er), "write response");
      end
    end
    if (!got) hang("write");
  endtask

  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    bit got;
    got = 0;
    @(posedge mclk_in);
    axi_in.arvalid <= 1'b1;
    axi_in.araddr  <= a;
    axi_in.rready  <= 1'b1;
    for (int i = 0; i < 64 && !got; i++) begin
      @(posedge mclk_in);
      if (axi_in.arvalid && axi_out.arready === 1'b1) axi_in.arvalid <= 1'b0;
      if (axi_out.rvalid === 1'b1) begin
        got = 1;
        rd = axi_out.rdata;
        axi_in.rready <= 1'b0;
        chk(32'(axi_out.rresp), 32'(er), "read response");
      end
    end
    if (!got) hang("read");
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string what);
    rdr(a, RESP_OKAY);
    chk(rd & m, e, what);
  endtask

  // one-cycle frame offer, then count load pulses over the following three cycles
  task automatic frm(input logic ext, input logic [28:0] id, input logic [15:0] dat,
                     input logic ez, input logic eo);
    int nz;
    int no;
    nz = 0;
    no = 0;
    @(posedge mclk_in);
    frame_valid_in <= 1'b1;
    frame_in       <= frame_t'({ext, id, dat});
    @(posedge mclk_in);
    frame_valid_in <= 1'b0;
    repeat (3) begin
      @(negedge mclk_in);
      nz += (load_zero_out === 1'b1);
      no += (load_one_out === 1'b1);
    end
    chk(32'(nz), 32'(ez), "buffer zero loads");
    chk(32'(no), 32'(eo), "buffer one loads");
  endtask

  // the timer may free-run while idle, so strobes count only after the hard sync;
  // a node one clock slow per bit lags past the alignment slot by bit six, whose
  // falling edge then stretches phase one by the one-quantum jump width
  task automatic bits(input logic tri_s, input int period);
    int t;
    wr(OFS_TIMING, 32'h1 | (32'h1 << TM_PH1) | (32'(tri_s) << TM_SAM), RESP_OKAY);
    fork
      can_node_model_i.send(PAT, period);
      begin
        t = 0;
        do begin @(posedge mclk_in); t++; end while (rx_in !== 1'b0 && t < 10);
        if (t >= 10) hang("start of frame");
        repeat (3) @(posedge mclk_in);
        chk(32'(segment_out), 32'(SEG_SYNC), "hard sync segment");
        bus_idle_in <= 1'b0;
        for (int k = 0; k < 8; k++) begin
          t = 0;
          do begin @(posedge mclk_in); t++; end while (bit_strobe_out !== 1'b1 && t < 60);
          if (t >= 60) hang("bit strobe");
          chk(32'(bit_value_out), 32'(PAT[k]), "sampled bit");
          if (k > 0) chk(32'(t), (period != 24 && k == 6) ? 32'd28 : 32'd24,
                         "bit length");
        end
      end
    join
    bus_idle_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
  endtask

  initial begin
    repeat (4) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    rchk(OFS_CTRL, 32'h3, 32'h1, "control after reset");
    rchk(OFS_TIMING, 32'h1FFFFFF, 32'h0, "timing after reset");
    rdr(8'hFC, RESP_SLVERR);
    chk(rd, 32'h0, "unmapped read");
    wr(OFS_MASK0, 32'h1FFFFFFF, RESP_OKAY);
    wr(OFS_MASK1, 32'h1FFFFF00, RESP_OKAY);
    for (int k = 0; k < 6; k++) wr(OFS_FILT0 + 8'(4 * k), {3'b0, filt[k]}, RESP_OKAY);
    rchk(OFS_MASK1, 32'hFFFFFFFF, 32'h1FFFFF00, "mask in configuration");
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    rchk(OFS_MASK0, 32'hFFFFFFFF, 32'h0, "mask outside configuration");
    rchk(OFS_FILT0 + 8'h08, 32'hFFFFFFFF, 32'h0, "filter outside configuration");
    wr(OFS_FILT0, 32'h0, RESP_OKAY);
    frm(1'b1, ID_A, 16'h0, 1'b1, 1'b0);
    rchk(OFS_STATUS, SM, 32'h100, "filter zero kept");
    frm(1'b1, ID_B, 16'h0, 1'b0, 1'b1);
    rchk(OFS_STATUS, SM, 32'h330, "zero full, lowest of two to five");
    wr(OFS_STATUS, 32'h300, RESP_OKAY);
    frm(1'b1, ID_B, 16'h0, 1'b1, 1'b0);
    rchk(OFS_STATUS, SM, 32'h131, "filter one kept");
    wr(OFS_STATUS, 32'h300, RESP_OKAY);
    frm(1'b1, ID_A ^ 29'h1, 16'h0, 1'b0, 1'b0);
    for (int k = 2; k < 6; k++) if (k != 3) begin
      frm(1'b1, filt[k] | 29'h5A, 16'h0, 1'b0, 1'b1);
      rchk(OFS_STATUS, SM, 32'h201 | (32'(k) << 4), "hit code");
      wr(OFS_STATUS, 32'h300, RESP_OKAY);
    end
    frm(1'b0, {11'h2A5, 18'h0}, 16'hC3C3, 1'b0, 1'b1);
    rchk(OFS_STATUS, SM, 32'h241, "standard frame data match");
    wr(OFS_STATUS, 32'h300, RESP_OKAY);
    frm(1'b0, {11'h2A5, 18'h0}, 16'h3CC3, 1'b0, 1'b0);
    wr(OFS_CTRL, 32'h2, RESP_OKAY);
    frm(1'b1, ID_A, 16'h0, 1'b1, 1'b0);
    frm(1'b1, ID_A, 16'h0, 1'b0, 1'b1);
    rchk(OFS_STATUS, SM, 32'h306, "rolled filter zero");
    frm(1'b1, ID_B, 16'h0, 1'b0, 1'b0);
    wr(OFS_STATUS, 32'h300, RESP_OKAY);
    bits(1'b0, 24);
    bits(1'b1, 24);
    bits(1'b0, 25);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    rchk(OFS_FILT0, 32'hFFFFFFFF, {3'b0, ID_A}, "filter write ignored");
    end_of_test();
  end
endmodule // can_accept_filter_bit_timing_test
